// ==== hdl/sersq_top.sv ====
// sersq_top: two-wire eeprom target, read sequencing and word address counter
// assumes: array read port answers within a few clocks; scl far slower than clk
`include "sersq_regs.svh"
// ----------------------------------------
// write buffer
// ----------------------------------------
module sersq_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `SERSQ_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
    $error("sersq_fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [PW-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
  logic [PW:0] cnt_reg, cnt_next;
  logic ovalid_reg, ovalid_next;
  logic [WIDTH-1:0] odata_reg, odata_next;
  logic push, pop;
  // ready is honest: storage only, output stage drains separately
  assign in_ready = (cnt_reg != (PW+1)'(DEPTH));
  assign push = in_valid && in_ready;
  assign pop = (cnt_reg != '0) && (!ovalid_reg || out_ready);
  assign out_valid = ovalid_reg;
  assign out_data = odata_reg;
  always_comb begin
    mem_next = mem_reg;
    wptr_next = wptr_reg;
    rptr_next = rptr_reg;
    cnt_next = cnt_reg;
    ovalid_next = ovalid_reg;
    odata_next = odata_reg;
    if (push) begin
      mem_next[wptr_reg] = in_data;
      wptr_next = wptr_reg + 1'b1;
    end
    if (pop) begin
      odata_next = mem_reg[rptr_reg];
      ovalid_next = 1'b1;
      rptr_next = rptr_reg + 1'b1;
    end else if (out_ready) begin
      ovalid_next = 1'b0;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg <= '0;
      ovalid_reg <= 1'b0;
      odata_reg <= '0;
    end else begin
      mem_reg <= mem_next;
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      cnt_reg <= cnt_next;
      ovalid_reg <= ovalid_next;
      odata_reg <= odata_next;
    end
  end
endmodule // sersq_fifo
// ----------------------------------------
// protocol engine
// ----------------------------------------
module sersq_top
  import sersq_pkg::*;
#(
  parameter int ADDR_W = `SERSQ_ADDR_W,
  parameter int PAGE_W = `SERSQ_PAGE_W,
  parameter int FIFO_DEPTH = `SERSQ_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic select_pin_high,
  input wire logic select_pin_mid,
  input wire logic select_pin_low,
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [7:0] rd_data,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [7:0] wr_data,
  output logic standby
);
  localparam int HI_W = ADDR_W - 8;
  if (ADDR_W <= 8 || ADDR_W > 16 || PAGE_W < 1 || PAGE_W >= ADDR_W) begin : g_chk
    $error("sersq_top address or page width out of range");
  end
  // read step: whole array rolls over
  function automatic logic [ADDR_W-1:0] rd_inc(input logic [ADDR_W-1:0] a);
    rd_inc = a + 1'b1;
  endfunction
  // write step: only the in-page bits move
  function automatic logic [ADDR_W-1:0] wr_inc(input logic [ADDR_W-1:0] a);
    logic [PAGE_W-1:0] lo;
    lo = a[PAGE_W-1:0] + 1'b1;
    wr_inc = {a[ADDR_W-1:PAGE_W], lo};
  endfunction
  // ----------------------------------------
  // pin synchronisers and edge finding
  // ----------------------------------------
  logic [1:0] scl_sy_reg, scl_sy_next, sda_sy_reg, sda_sy_next;
  logic scl_d_reg, scl_d_next, sda_d_reg, sda_d_next;
  logic [2:0] sel_sy1_reg, sel_sy1_next, sel_reg, sel_next;
  logic scl_s, sda_s, scl_rise, scl_fall, start_ev, stop_ev;
  assign scl_s = scl_sy_reg[1];
  assign sda_s = sda_sy_reg[1];
  assign scl_rise = scl_s && !scl_d_reg;
  assign scl_fall = !scl_s && scl_d_reg;
  // data moving while clock stays high marks start or stop
  assign start_ev = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign stop_ev = scl_s && scl_d_reg && !sda_d_reg && sda_s;
  always_comb begin
    scl_sy_next = {scl_sy_reg[0], scl_i};
    sda_sy_next = {sda_sy_reg[0], sda_i};
    scl_d_next = scl_s;
    sda_d_next = sda_s;
    sel_sy1_next = {select_pin_high, select_pin_mid, select_pin_low};
    sel_next = sel_sy1_reg;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_sy_reg <= 2'h3;
      sda_sy_reg <= 2'h3;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      sel_sy1_reg <= 3'h0;
      sel_reg <= 3'h0;
    end else begin
      scl_sy_reg <= scl_sy_next;
      sda_sy_reg <= sda_sy_next;
      scl_d_reg <= scl_d_next;
      sda_d_reg <= sda_d_next;
      sel_sy1_reg <= sel_sy1_next;
      sel_reg <= sel_next;
    end
  end
  // ----------------------------------------
  // byte engine and word address counter
  // ----------------------------------------
  sersq_state_e state_reg, state_next, ret_reg, ret_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [HI_W-1:0] ahi_reg, ahi_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic oe_reg, oe_next, mack_reg, mack_next, standby_reg, standby_next;
  logic byte_end, dev_match, push, fifo_ready;
  logic [ADDR_W-1:0] load_addr;
  assign byte_end = scl_fall && (cnt_reg == `SERSQ_BYTE_BITS);
  assign dev_match = (shift_reg[7:4] == `SERSQ_DEV_CODE) && (shift_reg[3:1] == sel_reg);
  assign load_addr = {ahi_reg, shift_reg};
  assign push = (state_reg == ST_WDAT) && byte_end && fifo_ready;
  always_comb begin
    state_next = state_reg;
    ret_next = ret_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    ahi_next = ahi_reg;
    addr_next = addr_reg;
    oe_next = oe_reg;
    mack_next = mack_reg;
    standby_next = standby_reg;
    if (start_ev) begin
      state_next = ST_DEV;
      cnt_next = `SERSQ_CNT_ZERO;
      oe_next = 1'b0;
      standby_next = 1'b0;
    end else if (stop_ev) begin
      state_next = ST_IDLE;
      oe_next = 1'b0;
      standby_next = 1'b1;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
        end
        ST_DEV, ST_AHI, ST_ALO, ST_WDAT: begin
          if (scl_rise && cnt_reg != `SERSQ_BYTE_BITS) begin
            shift_next = {shift_reg[6:0], sda_s};
            cnt_next = cnt_reg + `SERSQ_CNT_ONE;
          end else if (byte_end) begin
            cnt_next = `SERSQ_CNT_ZERO;
            state_next = ST_ACK;
            oe_next = 1'b1;
            if (state_reg == ST_DEV) begin
              if (!dev_match) begin
                state_next = ST_IDLE;
                oe_next = 1'b0;
                standby_next = 1'b1;
              end else if (shift_reg[0]) begin
                ret_next = ST_TX;
              end else begin
                ret_next = ST_AHI;
              end
            end else if (state_reg == ST_AHI) begin
              ahi_next = shift_reg[HI_W-1:0];
              ret_next = ST_ALO;
            end else if (state_reg == ST_ALO) begin
              addr_next = load_addr;
              ret_next = ST_WDAT;
            end else if (fifo_ready) begin
              addr_next = wr_inc(addr_reg);
              ret_next = ST_WDAT;
            end else begin
              // buffer full: refuse the byte rather than drop it
              state_next = ST_IDLE;
              oe_next = 1'b0;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (ret_reg == ST_TX) begin
              oe_next = !rd_data[7];
              shift_next = {rd_data[6:0], 1'b0};
              cnt_next = `SERSQ_CNT_ONE;
            end else begin
              oe_next = 1'b0;
            end
            state_next = ret_reg;
          end
        end
        ST_TX: begin
          if (byte_end) begin
            oe_next = 1'b0;
            addr_next = rd_inc(addr_reg);
            state_next = ST_MACK;
          end else if (scl_fall) begin
            oe_next = !shift_reg[7];
            shift_next = {shift_reg[6:0], 1'b0};
            cnt_next = cnt_reg + `SERSQ_CNT_ONE;
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            mack_next = !sda_s;
          end else if (scl_fall) begin
            if (mack_reg) begin
              oe_next = !rd_data[7];
              shift_next = {rd_data[6:0], 1'b0};
              cnt_next = `SERSQ_CNT_ONE;
              state_next = ST_TX;
            end else begin
              state_next = ST_IDLE;
            end
          end
        end
      endcase
    end
  end
  // counter reset only by nrst, at any time; never cleared by bus events
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      ret_reg <= ST_IDLE;
      cnt_reg <= `SERSQ_CNT_ZERO;
      shift_reg <= 8'h00;
      ahi_reg <= '0;
      addr_reg <= '0;
      oe_reg <= 1'b0;
      mack_reg <= 1'b0;
      standby_reg <= `SERSQ_STANDBY_RST;
    end else begin
      state_reg <= state_next;
      ret_reg <= ret_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      ahi_reg <= ahi_next;
      addr_reg <= addr_next;
      oe_reg <= oe_next;
      mack_reg <= mack_next;
      standby_reg <= standby_next;
    end
  end
  assign sda_o = 1'b0;
  assign sda_oe = oe_reg;
  assign rd_addr = addr_reg;
  assign standby = standby_reg;
  sersq_fifo #(.WIDTH(ADDR_W + 8), .DEPTH(FIFO_DEPTH)) u_wbuf (
    .clk(clk),
    .nrst(nrst),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data({addr_reg, shift_reg}),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data({wr_addr, wr_data})
  );
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  ack_on_match_a: assert property ((state_reg == ST_DEV && byte_end && dev_match)
    |=> oe_reg && state_reg == ST_ACK) else $error("matched address not acked");
  idle_on_miss_a: assert property ((state_reg == ST_DEV && byte_end && !dev_match)
    |=> !oe_reg && state_reg == ST_IDLE && standby_reg) else $error("mismatch answered");
  read_wrap_a: assert property ((state_reg == ST_TX && byte_end && !start_ev && !stop_ev)
    |=> addr_reg == ADDR_W'($past(addr_reg) + 1'b1)) else $error("read step wrong");
  write_wrap_a: assert property (push && !start_ev && !stop_ev
    |=> addr_reg[ADDR_W-1:PAGE_W] == $past(addr_reg[ADDR_W-1:PAGE_W]))
    else $error("write step left page");
  mack_release_a: assert property (state_reg == ST_MACK |-> !oe_reg)
    else $error("data driven in ack slot");
  seq_continue_a: assert property ((state_reg == ST_MACK && scl_fall && mack_reg
    && !start_ev && !stop_ev) |=> state_reg == ST_TX && cnt_reg == `SERSQ_CNT_ONE)
    else $error("ack did not continue read");
  stop_standby_a: assert property (stop_ev && !start_ev
    |=> standby_reg && state_reg == ST_IDLE && !oe_reg) else $error("stop missed");
  addr_load_a: assert property ((state_reg == ST_ALO && byte_end && !start_ev && !stop_ev)
    |=> addr_reg == $past(load_addr)) else $error("word address not loaded");
  hold_addr_a: assert property ((state_reg == ST_IDLE) && !start_ev
    |=> $stable(addr_reg)) else $error("counter moved while idle");
  cur_read_c: cover property (state_reg == ST_DEV && byte_end && dev_match && shift_reg[0]);
  rand_read_c: cover property (state_reg == ST_ALO && byte_end ##[1:1000] state_reg == ST_TX);
  seq_read_c: cover property (state_reg == ST_MACK && scl_fall && mack_reg);
  wbuf_full_c: cover property (state_reg == ST_WDAT && byte_end && !fifo_ready);
endmodule // sersq_top

// ==== shared/sersq_regs.svh ====
// sersq_regs.svh: fixed codes, counts and reset values of the read sequencer
// assumes: included by its bare name in the design file and the testbench
// Function
// - three read kinds: current address, random address, sequential.
// - word address counter holds last accessed location plus one.
// - counter keeps its value between transactions while powered.
// - read increment wraps from top of array to address zero.
// - write increment wraps within the current page only.
// - current read: after acked read address, shift out byte at counter.
// - random read: ack read address, shift out byte at newly loaded address.
// - after each byte, increment counter; on controller ack, shift out next byte.
// - sequential read wraps past array top and keeps going.
// - bytes are eight bits; receiver acks by pulling data low on ninth clock.
// - match three select bits; ack on match, back to standby otherwise.
// - stop after a sequence puts the device in standby.
`ifndef SERSQ_REGS_SVH
`define SERSQ_REGS_SVH
`define SERSQ_DEV_CODE 4'ha
`define SERSQ_BYTE_BITS 4'h8
`define SERSQ_CNT_ZERO 4'h0
`define SERSQ_CNT_ONE 4'h1
`define SERSQ_ADDR_W 13
`define SERSQ_PAGE_W 5
`define SERSQ_FIFO_DEPTH 32
`define SERSQ_STANDBY_RST 1'b1
`endif

// ==== shared/sersq_pkg.sv ====
// sersq_pkg: state type used by the protocol engine of the read sequencer
// assumes: compiled before the design file
package sersq_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_DEV, ST_AHI, ST_ALO, ST_WDAT, ST_ACK, ST_TX, ST_MACK
  } sersq_state_e;
endpackage

// ==== verification/sersq_ctl_model.sv ====
// sersq_ctl_model: behavioural two-wire bus controller that drives the target
// assumes: sda is the resolved wire with a pull-up; one task runs at a time
module sersq_ctl_model (
  output logic scl,
  output logic pull,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  // ----------------------------------------
  // bit level
  // ----------------------------------------
  // low 200 ns, high 120 ns: the target's synchronised drive settles well before scl rises
  task automatic bit_out(input logic b);
    #100 pull = !b;
    #100 scl = 1'b1;
    #120 scl = 1'b0;
  endtask
  task automatic bit_in(output logic b);
    #100 pull = 1'b0;
    #100 scl = 1'b1;
    #60 b = sda;
    #60 scl = 1'b0;
  endtask
  // also serves as repeated start; scl stands high between frames
  task automatic start();
    #100 pull = 1'b0;
    #100 scl = 1'b1;
    #160 pull = 1'b1;
    #160 scl = 1'b0;
  endtask
  task automatic stop();
    #100 pull = 1'b1;
    #100 scl = 1'b1;
    #160 pull = 1'b0;
    #160;
  endtask
  // ----------------------------------------
  // byte level
  // ----------------------------------------
  task automatic wbyte(input logic [7:0] v, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) bit_out(v[i]); // msb first, ninth clock is ack
    bit_in(b);
    ack = !b;
  endtask
  task automatic rbyte(input logic ack, output logic [7:0] v);
    for (int i = 7; i >= 0; i--) bit_in(v[i]);
    bit_out(!ack); // low to go on, released before stop to end
  endtask
endmodule // sersq_ctl_model

// ==== verification/testbench.sv ====
// testbench: reads, writes and refusals through the controller model, array modelled here
// assumes: design files and sersq_ctl_model compiled first
`include "sersq_regs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic scl, pull, sda, sda_o, sda_oe, wr_ready, wr_valid, standby, k;
  logic [2:0] sel;
  logic [12:0] rd_addr, wr_addr;
  logic [7:0] rd_data, wr_data, d;
  logic [7:0] mem [8192];
  logic [20:0] wq [$];
  int errors = 0;
  int samples_checked = 0;
  int ctr = 0;
  assign sda = (sda_oe ? sda_o : 1'b1) & !pull;
  initial begin
    forever #20 clk = !clk;
  end
  always @(posedge clk) rd_data <= #1 mem[rd_addr];
  sersq_top #(.ADDR_W(13), .PAGE_W(5), .FIFO_DEPTH(32)) dut (
    .clk(clk), .nrst(nrst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .select_pin_high(sel[2]), .select_pin_mid(sel[1]), .select_pin_low(sel[0]),
    .rd_addr(rd_addr), .rd_data(rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_addr(wr_addr), .wr_data(wr_data), .standby(standby));
  sersq_ctl_model ctl (.scl(scl), .pull(pull), .sda(sda));
  // ----------------------------------------
  // checking and reporting
  // ----------------------------------------
  task automatic chk(input string what, input logic [20:0] seen, input logic [20:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #2_000_000;
    errors++;
    summarize();
  end
  // ----------------------------------------
  // transactions
  // ----------------------------------------
  task automatic dev(input logic [7:0] a, output logic ack);
    ctl.start();
    ctl.wbyte(a, ack);
  endtask
  task automatic setaddr(input logic [15:0] a);
    dev({`SERSQ_DEV_CODE, sel, 1'b0}, k);
    chk("dev ack w", k, 1'b1);
    ctl.wbyte(a[15:8], k); // dummy write of two address bytes
    chk("hi ack", k, 1'b1);
    ctl.wbyte(a[7:0], k);
    chk("lo ack", k, 1'b1);
    ctr = a[12:0]; // don't-care upper bits dropped
  endtask
  task automatic rd_byte(input logic more);
    ctl.rbyte(more, d);
    chk("rd byte", d, mem[ctr]);
    ctr = (ctr + 1) % 8192;
  endtask
  task automatic rd(input int n);
    dev({`SERSQ_DEV_CODE, sel, 1'b1}, k); // repeated start after setaddr, rw one
    chk("dev ack r", k, 1'b1);
    chk("standby busy", standby, 1'b0);
    for (int i = 0; i < n; i++) rd_byte(i < n - 1);
    ctl.stop();
    chk("standby", standby, 1'b1);
    chk("counter", rd_addr, 21'(ctr));
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'hd61907f3));
    wr_ready = 1'b0;
    sel = 3'($urandom);
    foreach (mem[i]) mem[i] = 8'($urandom);
    repeat (20) @(posedge clk);
    #1 nrst = 1'b1;
    #6;
    chk("rst oe", sda_oe, 1'b0);
    chk("rst addr", rd_addr, 21'h0);
    chk("rst wr_valid", wr_valid, 1'b0);
    chk("rst standby", standby, 1'b1);
    rd(1); // current read at the reset address
    rd(1); // counter kept between transactions
    setaddr({3'($urandom), 13'($urandom)});
    rd(3); // random read running on sequentially
    setaddr({3'h7, 13'h1ffe});
    rd(4); // passes the top of the array
    for (int s = 0; s < 9; s++) begin
      dev(s < 8 ? {`SERSQ_DEV_CODE, 3'(s), 1'b1} : {4'h5, sel, 1'b1}, k);
      chk("select ack", k, s < 8 && 3'(s) == sel);
      if (k) rd_byte(1'b0);
      ctl.stop();
      chk("standby idle", standby, 1'b1);
    end
    // consumer stalls so the buffer fills: 32 deep plus the output stage
    setaddr({3'($urandom), 8'($urandom), 5'h1e});
    for (int i = 0; i < 34; i++) begin
      d = 8'($urandom);
      ctl.wbyte(d, k);
      chk("wr ack", k, i < 33);
      if (k) begin
        wq.push_back({ctr[12:0], d});
        ctr = {ctr[12:5], ctr[4:0] + 5'h1};
      end
    end
    ctl.stop();
    for (int t = 0; t < 3000 && wq.size() > 0; t++) begin
      @(posedge clk);
      #1 wr_ready = 1'($urandom_range(1));
      @(negedge clk);
      if (wr_valid === 1'b1 && wr_ready) chk("wr entry", {wr_addr, wr_data}, wq.pop_front());
    end
    chk("drained", 21'(wq.size()), 21'h0);
    @(posedge clk);
    #1 wr_ready = 1'b0;
    @(negedge clk);
    chk("wr empty", wr_valid, 1'b0);
    @(posedge clk);
    #7;
    rd(2); // continues after the last written byte, then runs into the next page
    // mid-run reset, applied and released on the bench's stimulus phase
    repeat (25) @(posedge clk);
    #1 nrst = 1'b0;
    @(posedge clk);
    #1 nrst = 1'b1;
    ctr = 0;
    chk("rst2 standby", standby, 1'b1);
    chk("rst2 addr", rd_addr, 21'h0);
    #6;
    rd(1);
    summarize();
  end
endmodule // testbench
